// [shared/servo_amp_pkg.sv]
// constants, register map and reset codes of the servo amplifier control block
`default_nettype none
package servo_amp_pkg;
   // clock and pwm timing
   localparam int CLK_HZ = 10_000_000;
   localparam int PWM_HZ = 24_000;
   localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
   localparam int AVG_WINDOW_MS = 1000;
   localparam int AVG_WINDOW_CYC = CLK_HZ / 1000 * AVG_WINDOW_MS;
   localparam int AXES = 4;
   // apb register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_HALL = 8'h0C;
   localparam logic [7:0] OFS_GAIN = 8'h10;
   localparam logic [7:0] OFS_PEAK = 8'h14;
   localparam logic [7:0] OFS_CONT = 8'h18;
   localparam logic [7:0] OFS_CMDV = 8'h1C;
   localparam logic [7:0] OFS_BW = 8'h20;
   // ctrl field positions
   localparam int CTRL_BRUSH_LSB = 0;
   localparam int CTRL_BOOST_LSB = 4;
   localparam int CTRL_PHASE60_LSB = 8;
   localparam int CTRL_OFF_ON_ERR_LSB = 12;
   localparam int CTRL_RELAY_BIT = 16;
   // cmd register bits
   localparam int CMD_DISABLE_BIT = 0;
   localparam int CMD_ENABLE_BIT = 1;
   localparam int CMD_HALL_CLR_BIT = 2;
   // reset values and codes
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [7:0] PEAK_RST = 8'h7F;
   localparam logic [7:0] CONT_RST = 8'h7F;
   localparam logic [7:0] LOCKOUT_CODE = 8'h03;
   localparam logic [1:0] GAIN_MAX_CODE = 2'h2;
   // bandwidth helper: bw_hz = supply * scale / inductance, scale by boost
   localparam logic [31:0] BW_SCALE_NORM = 32'h0000_03E8;
   localparam logic [31:0] BW_SCALE_BOOST = 32'h0000_07D0;
endpackage
`default_nettype wire

// [src/servo_amplifier_control.sv]
// per-axis servo amplifier control: lockout, relay, hall, limits, chopper pwm
`default_nettype none
module servo_amplifier_control
(
   input wire logic clk, // 10 MHz system clock
   input wire logic rst, // async reset, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic emergency_lockout_input, // lockout, high when tripped
   input wire logic [11:0] hall_in, // three halls per axis
   output logic [3:0] pwm_pos, // forward rail switch per axis
   output logic [3:0] pwm_neg, // reverse rail switch per axis
   output logic [3:0] amp_enable, // power stage enable per axis
   output logic relay_closed, // solid state relay closed
   output logic fault_handler_routine // request to run fault handler
);
   typedef enum {ST_RUN, ST_OFF, ST_LOCKED, ST_LOCK_DIS} drive_e;
   typedef struct packed {
      drive_e state;
      logic [31:0] ctrl;
      logic [7:0] gain;
      logic [31:0] peak;
      logic [31:0] cont;
      logic [31:0] cmdv;
      logic [31:0] bw_in;
      logic [31:0] bw_out;
      logic [3:0] hall_err;
      logic [3:0] over_cont;
      logic [9:0] pwm_cnt;
      logic [23:0] win_cnt;
      logic [4*32-1:0] acc;
      logic [3:0] pos;
      logic [3:0] neg;
      logic [31:0] rdata;
      logic handler;
   } state_s;
   state_s cur_r, cur_nxt;

   // magnitude of a signed 8-bit command
   function automatic logic [7:0] mag8(input logic [7:0] v);
      mag8 = v[7] ? 8'(-v) : v;
   endfunction

   // illegal hall pattern for 120 degree phasing
   function automatic logic hall_bad(input logic [2:0] h, input logic p60);
      hall_bad = !p60 && (h == 3'b000 || h == 3'b111);
   endfunction

   logic wr_en, rd_en, addr_ok, locked;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = paddr <= servo_amp_pkg::OFS_BW && paddr[1:0] == 2'b00;
   assign locked = cur_r.state == ST_LOCKED || cur_r.state == ST_LOCK_DIS;

   // next-state logic: bus, drive sequencer, hall, limits and pwm
   always_comb
   begin
      logic [7:0] lim;
      logic [7:0] m;
      logic [3:0] off_on_err;
      logic dis_cmd, en_cmd;
      lim = 8'h00;
      m = 8'h00;
      cur_nxt = cur_r;
      off_on_err = cur_r.ctrl[servo_amp_pkg::CTRL_OFF_ON_ERR_LSB +: 4];
      dis_cmd = wr_en && paddr == servo_amp_pkg::OFS_CMD
         && pwdata[servo_amp_pkg::CMD_DISABLE_BIT];
      en_cmd = wr_en && paddr == servo_amp_pkg::OFS_CMD
         && pwdata[servo_amp_pkg::CMD_ENABLE_BIT];
      // register writes
      if (wr_en)
      begin
         case (paddr)
            servo_amp_pkg::OFS_CTRL: cur_nxt.ctrl = pwdata;
            servo_amp_pkg::OFS_GAIN:
            begin
               for (int a = 0; a < 4; a++)
                  if (pwdata[2*a +: 2] <= servo_amp_pkg::GAIN_MAX_CODE)
                     cur_nxt.gain[2*a +: 2] = pwdata[2*a +: 2];
            end
            servo_amp_pkg::OFS_PEAK: cur_nxt.peak = pwdata;
            servo_amp_pkg::OFS_CONT: cur_nxt.cont = pwdata;
            servo_amp_pkg::OFS_CMDV: cur_nxt.cmdv = pwdata;
            servo_amp_pkg::OFS_BW:
            begin
               // bandwidth helper: [15:0] supply volts, [23:16] mH, [24] boost
               cur_nxt.bw_in = pwdata;
               cur_nxt.bw_out = (pwdata[23:16] == 8'h00) ? 32'h0000_0000 :
                  32'((32'(pwdata[15:0]) * (pwdata[24] ? servo_amp_pkg::BW_SCALE_BOOST
                  : servo_amp_pkg::BW_SCALE_NORM)) / 32'(pwdata[23:16]));
            end
            default: ;
         endcase
      end
      // drive state machine
      case (cur_r.state)
         ST_RUN, ST_OFF:
         begin
            if (dis_cmd)
               cur_nxt.state = ST_OFF;
            else if (en_cmd)
               cur_nxt.state = ST_RUN;
            if (cur_r.state == ST_RUN && |(cur_r.hall_err & off_on_err))
               cur_nxt.state = ST_OFF;
         end
         ST_LOCKED:
            if (dis_cmd && !emergency_lockout_input)
               cur_nxt.state = ST_LOCK_DIS;
         ST_LOCK_DIS:
            if (en_cmd && !emergency_lockout_input)
               cur_nxt.state = ST_RUN;
         default: cur_nxt.state = ST_OFF;
      endcase
      if (emergency_lockout_input)
         cur_nxt.state = ST_LOCKED;
      // hall monitoring, sticky until cleared, set wins
      if (wr_en && paddr == servo_amp_pkg::OFS_CMD && pwdata[servo_amp_pkg::CMD_HALL_CLR_BIT])
         cur_nxt.hall_err = 4'h0;
      for (int a = 0; a < 4; a++)
      begin
         // brushed axis has no hall protection
         if (!cur_r.ctrl[servo_amp_pkg::CTRL_BRUSH_LSB + a]
            && hall_bad(hall_in[3*a +: 3], cur_r.ctrl[servo_amp_pkg::CTRL_PHASE60_LSB + a]))
            cur_nxt.hall_err[a] = 1'b1;
      end
      // handler request on lockout or hall error
      cur_nxt.handler = emergency_lockout_input || |cur_nxt.hall_err;
      cur_nxt.pwm_cnt = (cur_r.pwm_cnt == 10'(servo_amp_pkg::PWM_PERIOD_CYC - 1)) ?
         10'h000 : 10'(cur_r.pwm_cnt + 10'h001);
      if (cur_r.win_cnt == 24'(servo_amp_pkg::AVG_WINDOW_CYC - 1))
      begin
         cur_nxt.win_cnt = 24'h00_0000;
         cur_nxt.acc = '0;
         cur_nxt.over_cont = 4'h0;
      end
      else
         cur_nxt.win_cnt = 24'(cur_r.win_cnt + 24'h00_0001);
      for (int a = 0; a < 4; a++)
      begin
         m = mag8(cur_r.cmdv[8*a +: 8]);
         lim = (m > cur_r.peak[8*a +: 8]) ? cur_r.peak[8*a +: 8] : m;
         // budget of cont limit times window
         if (cur_r.over_cont[a])
            lim = (lim > cur_r.cont[8*a +: 8]) ? cur_r.cont[8*a +: 8] : lim;
         if (cur_r.win_cnt != 24'(servo_amp_pkg::AVG_WINDOW_CYC - 1))
         begin
            cur_nxt.acc[32*a +: 32] = cur_r.acc[32*a +: 32] + 32'(lim);
            if (cur_r.acc[32*a +: 32] >= 32'(cur_r.cont[8*a +: 8])
               * 32'(servo_amp_pkg::AVG_WINDOW_CYC))
               cur_nxt.over_cont[a] = 1'b1;
         end
         // chopper: one rail per direction, other held off
         // gated by the next state, so a lockout stops switching with amp_enable
         cur_nxt.pos[a] = (cur_nxt.state == ST_RUN) && !cur_r.cmdv[8*a + 7]
            && ({2'b00, cur_r.pwm_cnt} < 12'(lim) * 12'd8);
         cur_nxt.neg[a] = (cur_nxt.state == ST_RUN) && cur_r.cmdv[8*a + 7]
            && ({2'b00, cur_r.pwm_cnt} < 12'(lim) * 12'd8);
      end
      // read mux
      case (paddr)
         servo_amp_pkg::OFS_CTRL: cur_nxt.rdata = cur_r.ctrl;
         servo_amp_pkg::OFS_STATUS:
            cur_nxt.rdata = {12'h000, cur_r.over_cont, cur_r.hall_err,
               locked ? servo_amp_pkg::LOCKOUT_CODE : 8'h00, 2'b00,
               cur_r.state == ST_RUN, locked};
         servo_amp_pkg::OFS_HALL: cur_nxt.rdata = {20'h0_0000, hall_in};
         servo_amp_pkg::OFS_GAIN: cur_nxt.rdata = {24'h00_0000, cur_r.gain};
         servo_amp_pkg::OFS_PEAK: cur_nxt.rdata = cur_r.peak;
         servo_amp_pkg::OFS_CONT: cur_nxt.rdata = cur_r.cont;
         servo_amp_pkg::OFS_CMDV: cur_nxt.rdata = cur_r.cmdv;
         servo_amp_pkg::OFS_BW: cur_nxt.rdata = cur_r.bw_out;
         default: cur_nxt.rdata = 32'h0000_0000;
      endcase
   end

   // state register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cur_r <= '0;
         cur_r.state <= ST_OFF;
         cur_r.ctrl <= servo_amp_pkg::CTRL_RST;
         cur_r.peak <= {4{servo_amp_pkg::PEAK_RST}};
         cur_r.cont <= {4{servo_amp_pkg::CONT_RST}};
      end
      else
         cur_r <= cur_nxt;
   end

   // apb answers in the access cycle; read data comes from the setup-cycle capture
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = (rd_en && addr_ok) ? cur_r.rdata : 32'h0000_0000;
   assign amp_enable = {4{cur_r.state == ST_RUN}};
   assign relay_closed = !cur_r.ctrl[servo_amp_pkg::CTRL_RELAY_BIT] || cur_r.state == ST_RUN;
   assign pwm_pos = cur_r.pos;
   assign pwm_neg = cur_r.neg;
   assign fault_handler_routine = cur_r.handler;

   a_lockout_off: assert property (@(posedge clk) disable iff (rst)
      emergency_lockout_input |=> (amp_enable == 4'h0 && pwm_pos == 4'h0))
      else $error("lockout did not disable drive");
   a_one_rail: assert property (@(posedge clk) disable iff (rst) (pwm_pos & pwm_neg) == 4'h0)
      else $error("both rails driven");
   a_lock_exit: assert property (@(posedge clk) disable iff (rst)
      (cur_r.state == ST_LOCK_DIS && $past(cur_r.state) == ST_LOCKED) |-> $past(!emergency_lockout_input))
      else $error("bad lockout exit");
   a_lock_hold: assert property (@(posedge clk) disable iff (rst)
      (cur_r.state == ST_LOCKED && !wr_en) |=> locked)
      else $error("lockout dropped");
   a_relay_open: assert property (@(posedge clk) disable iff (rst)
      (cur_r.ctrl[servo_amp_pkg::CTRL_RELAY_BIT] && cur_r.state != ST_RUN) |-> !relay_closed)
      else $error("relay closed while off");
   a_hall_flag: assert property (@(posedge clk) disable iff (rst)
      (hall_in[2:0] == 3'b111 && !cur_r.ctrl[0] && !cur_r.ctrl[8]) |=> cur_r.hall_err[0])
      else $error("hall error missed");
   // hall error with off-on-error stops drive
   a_hall_stop: assert property (@(posedge clk) disable iff (rst)
      (cur_r.hall_err[0] && cur_r.ctrl[12] && cur_r.state == ST_RUN) |=> cur_r.state != ST_RUN)
      else $error("hall error did not stop drive");
   a_handler: assert property (@(posedge clk) disable iff (rst)
      emergency_lockout_input |=> fault_handler_routine)
      else $error("handler not raised");
   a_lock_leave: assert property (@(posedge clk) disable iff (rst)
      locked |=> (locked || cur_r.state == ST_RUN))
      else $error("lockout left by a wrong path");
   a_gain_legal: assert property (@(posedge clk) disable iff (rst)
      cur_r.gain[1:0] != 2'h3 && cur_r.gain[3:2] != 2'h3 && cur_r.gain[5:4] != 2'h3
      && cur_r.gain[7:6] != 2'h3)
      else $error("illegal gain code stored");
   // pwm counter stays inside one period
   a_pwm_range: assert property (@(posedge clk) disable iff (rst)
      32'(cur_r.pwm_cnt) < servo_amp_pkg::PWM_PERIOD_CYC)
      else $error("pwm counter out of range");
   // pwm counter wraps at period end
   a_pwm_wrap: assert property (@(posedge clk) disable iff (rst)
      (cur_r.pwm_cnt == 10'(servo_amp_pkg::PWM_PERIOD_CYC - 1)) |=> cur_r.pwm_cnt == 10'h000)
      else $error("pwm counter did not wrap");
   // brushed axis raises no hall error
   a_brush_hall: assert property (@(posedge clk) disable iff (rst)
      (cur_r.ctrl[servo_amp_pkg::CTRL_BRUSH_LSB + 1] && !cur_r.hall_err[1]) |=> !cur_r.hall_err[1])
      else $error("hall error on brushed axis");
   // forward pulse never outlasts the peak limit
   a_peak_clamp: assert property (@(posedge clk) disable iff (rst)
      pwm_pos[0] |-> 32'($past(cur_r.pwm_cnt)) < 32'($past(cur_r.peak[7:0])) * 32'd8)
      else $error("pulse wider than peak limit");
endmodule
`default_nettype wire

// [testbench/hall_sensor_model.sv]
// hall sensor model standing in for the four motors
`default_nettype none
module hall_sensor_model
(
   input wire logic [11:0] hall_set, // sensor states chosen by the bench
   output logic [11:0] hall_in // levels seen by the block
);
   timeunit 1ns;
   timeprecision 1ns;
   // commutation set by user
   // each motor shows exactly the pattern the bench assigned, no auto search
   assign hall_in = hall_set;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the servo amplifier control block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lock_in = 1'b0, neg_sel = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, rerr, relay_closed, fault_handler_routine;
   logic [11:0] hall_set = 12'h249;
   logic [11:0] hall_w;
   logic [3:0] pwm_pos, pwm_neg, amp_enable;
   logic [7:0] gain_r, req;
   int err_count = 0;
   int tests_run = 0;
   int hi, per, oth_n;
   wire logic act = neg_sel ? pwm_neg[0] : pwm_pos[0];
   wire logic oth = neg_sel ? pwm_pos[0] : pwm_neg[0];
   // clock at 100 ns period
   always #50 clk = ~clk;
   servo_amplifier_control dut_u
   (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .emergency_lockout_input(lock_in), .hall_in(hall_w), .pwm_pos, .pwm_neg,
      .amp_enable, .relay_closed, .fault_handler_routine
   );
   hall_sensor_model hall_u
   (
      .hall_set(hall_set),
      .hall_in(hall_w)
   );
   // a code of 3 is refused, so that axis keeps its old gain
   function automatic logic [7:0] gain_exp(input logic [7:0] old, input logic [7:0] r);
      logic [7:0] g;
      g = old;
      for (int a = 0; a < 4; a++)
         if (r[2*a+:2] != 2'h3)
            g[2*a+:2] = r[2*a+:2];
      return g;
   endfunction
   function automatic logic [31:0] bw_exp(input int v, input int l, input int b);
      return v * (b ? servo_amp_pkg::BW_SCALE_BOOST : servo_amp_pkg::BW_SCALE_NORM) / l;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer; a spare edge after release keeps strobes apart
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n++ < 40) @(posedge clk);
      // a slave that never answers counts as a mismatch
      if (pready !== 1'b1)
         err_count++;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmd(input logic [31:0] d);
      apb(1'b1, servo_amp_pkg::OFS_CMD, d);
      repeat (2) @(posedge clk);
   endtask
   task automatic st(input logic [31:0] e);
      apb(1'b0, servo_amp_pkg::OFS_STATUS, 32'h0);
      chk("status", e, rdata);
   endtask
   // skips a whole period first so an old duty has run out
   task automatic measure();
      repeat (420) @(posedge clk);
      hi = 0;
      while (act !== 1'b0 && hi++ < 900) @(posedge clk);
      while (act !== 1'b1 && hi++ < 900) @(posedge clk);
      hi = 0;
      while (act === 1'b1 && hi++ < 900) @(posedge clk);
      per = hi;
      oth_n = 0;
      while (act !== 1'b1 && per++ < 900)
      begin
         oth_n += int'(oth !== 1'b0);
         @(posedge clk);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      void'($urandom(32'ha205_057f));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("relay", 32'h1, 32'(relay_closed));
      apb(1'b0, servo_amp_pkg::OFS_PEAK, 32'h0);
      chk("peak", 32'h7F7F_7F7F, rdata);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {rdata[30:0], rerr});
      // bring-up settings: low torque limit, off-on-error on every axis
      apb(1'b1, servo_amp_pkg::OFS_CONT, 32'h0303_0303);
      apb(1'b0, servo_amp_pkg::OFS_CONT, 32'h0);
      chk("cont", 32'h0303_0303, rdata);
      apb(1'b1, servo_amp_pkg::OFS_CTRL, 32'h0000_F000);
      cmd(32'h2);
      st(32'h2);
      chk("amp", 32'hF, 32'(amp_enable));
      lock_in <= 1'b1;
      repeat (4) @(posedge clk);
      st(32'h31);
      chk("amp", 32'h0, 32'(amp_enable));
      chk("handler", 32'h1, 32'(fault_handler_routine));
      lock_in <= 1'b0;
      cmd(32'h2);
      st(32'h31);
      cmd(32'h1);
      cmd(32'h2);
      st(32'h2);
      apb(1'b1, servo_amp_pkg::OFS_CTRL, 32'h0001_0000);
      chk("relay", 32'h1, 32'(relay_closed));
      cmd(32'h1);
      chk("relay", 32'h0, 32'(relay_closed));
      // off-on-error axis 0, brushed axis 1, boost 1 and 3, 60 degree axis 2, relay fitted
      apb(1'b1, servo_amp_pkg::OFS_CTRL, 32'h0001_14A2);
      apb(1'b0, servo_amp_pkg::OFS_CTRL, 32'h0);
      chk("ctrl", 32'h0001_14A2, rdata);
      cmd(32'h2);
      hall_set <= 12'h238;
      repeat (4) @(posedge clk);
      st(32'h1000);
      chk("amp", 32'h0, 32'(amp_enable));
      apb(1'b0, servo_amp_pkg::OFS_HALL, 32'h0);
      chk("hall", 32'h238, rdata);
      hall_set <= 12'h249;
      repeat (4) @(posedge clk);
      cmd(32'h4);
      cmd(32'h2);
      st(32'h2);
      apb(1'b1, servo_amp_pkg::OFS_PEAK, 32'h7F7F_7F0A);
      for (int s = 0; s < 2; s++)
      begin
         neg_sel <= s[0];
         apb(1'b1, servo_amp_pkg::OFS_CMDV, s ? 32'h0000_00EC : 32'h0000_0014);
         measure();
         chk("width", 32'd80, 32'(hi));
         chk("period", 32'(servo_amp_pkg::PWM_PERIOD_CYC), 32'(per));
         chk("other rail", 32'h0, 32'(oth_n));
      end
      for (int b = 0; b < 2; b++)
      begin
         // boost only above 5 mH on a 24 V supply
         apb(1'b1, servo_amp_pkg::OFS_BW, {7'h0, b[0], b ? 8'd6 : 8'd4, 16'd24});
         apb(1'b0, servo_amp_pkg::OFS_BW, 32'h0);
         chk("bandwidth", bw_exp(24, b ? 6 : 4, b), rdata);
      end
      gain_r = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         // corner 2: external amp on brushed axis 1 takes gain 1
         req = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'h04 : 8'($urandom);
         apb(1'b1, servo_amp_pkg::OFS_GAIN, {24'h0, req});
         gain_r = gain_exp(gain_r, req);
         apb(1'b0, servo_amp_pkg::OFS_GAIN, 32'h0);
         chk("gain", {24'h0, gain_r}, rdata);
      end
      // lockout, then a controller reset as the second way out
      lock_in <= 1'b1;
      repeat (2) @(posedge clk);
      st(32'h31);
      lock_in <= 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("handler", 32'h0, 32'(fault_handler_routine));
      chk("relay", 32'h1, 32'(relay_closed));
      st(32'h0);
      complete_run();
   end
   // watchdog: the sequence needs under 3000 cycles, allow over six times that
   initial
   begin
      #(20_000 * 100);
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire
